// ==== verilog/emu_regs_pkg.sv ====
// Constants, field layouts and carrier types of the identification and
// emulation register bank. Assumes a 16-bit byte address on AXI4-Lite.
`default_nettype none
package emu_regs_pkg;

  // ***************************************************************
  // Address map
  // ***************************************************************
  localparam int ADDR_W = 16;
  localparam logic [15:0] ID_OFFSET = 16'h0000;
  localparam logic [15:0] EMU_OFFSET = 16'h0004;
  localparam logic [15:0] TX_MAP_A = 16'h8000;
  localparam logic [15:0] TX_MAP_B = 16'h8100;
  localparam logic [15:0] RX_MAP_A = 16'hC000;
  localparam logic [15:0] RX_MAP_B = 16'hC100;
  localparam int MAP_WORDS = 8;
  localparam int MAP_TABLES = 4;

  // ***************************************************************
  // Field positions and reset values
  // ***************************************************************
  localparam int IDENT_LSB = 16;
  localparam int MAJOR_LSB = 8;
  localparam int MINOR_LSB = 0;
  localparam int SPARE_LSB = 20;
  localparam int SPARE_MSB = 24;
  localparam int LOOP_PATH_BIT = 17;
  localparam int LOOP_EN_BIT = 16;
  localparam int HALT_SCOPE_BIT = 1;
  localparam int FREE_RUN_BIT = 0;
  localparam logic [31:0] MAP_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ***************************************************************
  // Carrier types
  // ***************************************************************
  typedef struct packed {
    logic [4:0] spare;
    logic loopPath;
    logic loopEnable;
    logic haltScope;
    logic freeRun;
  } emuCtl_t;

  localparam emuCtl_t EMU_RESET = '0;

  typedef struct packed {
    logic serialUnit;
    logic txMux;
    logic txTransfer;
    logic rxMux;
    logic rxTransfer;
  } haltVec_t;

  typedef struct packed {
    logic active;
    logic internalPath;
    logic externalPath;
  } loopMode_t;

  typedef enum logic [1:0] {
    RUNNING = 2'b00,
    WAIT_FRAME = 2'b01,
    HALTED = 2'b11
  } haltState_t;

endpackage
`default_nettype wire

// ==== verilog/bit_synchronizer.sv ====
// Two-flop synchroniser for one level arriving from another domain.
// Assumes the level is stable for at least two destination clocks.
`timescale 1ns/1ps
`default_nettype none
module bit_synchronizer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta;

  // The first stage feeds only the second one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end

endmodule // bit_synchronizer
`default_nettype wire

// ==== verilog/emu_regs.sv ====
// Identification, emulation and test control, and timeslot bitmap tables.
// Assumes an AXI4-Lite master on mclk and frame ends from the serial unit.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module emu_regs
  import emu_regs_pkg::*;
#(
  parameter logic [15:0] MODULE_ID = 16'h0A5A, // Arbitrary value.
  parameter logic [7:0] REV_MAJOR = 8'h0C, // Arbitrary value.
  parameter logic [7:0] REV_MINOR = 8'h03 // Arbitrary value.
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic haltRequest,
  input wire logic frameDone,
  input wire logic [1:0] mapReadTable,
  input wire logic [2:0] mapReadWord,
  output logic [31:0] mapReadData,
  output loopMode_t loopMode,
  output haltVec_t haltVec
);

  // ***************************************************************
  // Address decode
  // ***************************************************************
  function automatic logic [3:0] mapDecode(input logic [ADDR_W-1:0] a);
    logic [3:0] hit;
    hit[0] = (a[15:5] == TX_MAP_A[15:5]);
    hit[1] = (a[15:5] == TX_MAP_B[15:5]);
    hit[2] = (a[15:5] == RX_MAP_A[15:5]);
    hit[3] = (a[15:5] == RX_MAP_B[15:5]);
    return hit;
  endfunction

  function automatic logic [31:0] applyStrobe(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  emuCtl_t emuCtl;
  logic [31:0] mapMem [MAP_TABLES*MAP_WORDS];

  wire [3:0] wrMapHit = mapDecode(wrAddr);
  wire [3:0] rdMapHit = mapDecode(araddr);
  wire wrIsId = (wrAddr == ID_OFFSET);
  wire wrIsEmu = (wrAddr == EMU_OFFSET);
  wire wrIsMap = (|wrMapHit) && (wrAddr[1:0] == 2'b00);
  wire rdIsId = (araddr == ID_OFFSET);
  wire rdIsEmu = (araddr == EMU_OFFSET);
  wire rdIsMap = (|rdMapHit) && (araddr[1:0] == 2'b00);
  wire [1:0] wrTable = {wrMapHit[2] | wrMapHit[3], wrMapHit[1] | wrMapHit[3]};
  wire [1:0] rdTable = {rdMapHit[2] | rdMapHit[3], rdMapHit[1] | rdMapHit[3]};
  wire [4:0] wrIndex = {wrTable, wrAddr[4:2]};
  wire [4:0] rdIndex = {rdTable, araddr[4:2]};
  wire doWrite = awHeld && wHeld && !bvalid;
  wire takeRead = arvalid && arready;

  // ***************************************************************
  // AXI4-Lite write channel
  // ***************************************************************
  // Address and data are captured independently, so either may come first.
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      awHeld <= 1'b0;
      wrAddr <= '0;
    end else if (awvalid && awready) begin
      awHeld <= 1'b1;
      wrAddr <= awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wHeld <= 1'b0;
      wrData <= '0;
      wrStrb <= '0;
    end else if (wvalid && wready) begin
      wHeld <= 1'b1;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // Writes to the identification word are accepted and have no effect.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (wrIsId || wrIsEmu || wrIsMap) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Control register and bitmap tables
  // ***************************************************************
  wire [31:0] emuWord = {7'h00, emuCtl.spare, 2'b00, emuCtl.loopPath,
                         emuCtl.loopEnable, 14'h0000, emuCtl.haltScope,
                         emuCtl.freeRun};
  wire [31:0] emuNew = applyStrobe(emuWord, wrData, wrStrb);
  wire emuCtl_t next_emuCtl = '{spare: emuNew[SPARE_MSB:SPARE_LSB],
                                loopPath: emuNew[LOOP_PATH_BIT],
                                loopEnable: emuNew[LOOP_EN_BIT],
                                haltScope: emuNew[HALT_SCOPE_BIT],
                                freeRun: emuNew[FREE_RUN_BIT]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      emuCtl <= EMU_RESET;
    end else if (doWrite && wrIsEmu) begin
      emuCtl <= next_emuCtl;
    end
  end

  genvar e;
  generate
    for (e = 0; e < MAP_TABLES*MAP_WORDS; e++) begin : gMap
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          mapMem[e] <= MAP_RESET;
        end else if (doWrite && wrIsMap && wrIndex == 5'(e)) begin
          mapMem[e] <= applyStrobe(mapMem[e], wrData, wrStrb);
        end
      end
    end
  endgenerate

  // The datapath reads the tables through its own port, one cycle late.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mapReadData <= MAP_RESET;
    end else begin
      mapReadData <= mapMem[{mapReadTable, mapReadWord}];
    end
  end

  // ***************************************************************
  // AXI4-Lite read channel
  // ***************************************************************
  wire [31:0] idWord = {MODULE_ID, REV_MAJOR, REV_MINOR};
  wire [31:0] readMux = rdIsId ? idWord : rdIsEmu ? emuWord :
                        rdIsMap ? mapMem[rdIndex] : 32'h0000_0000;

  assign arready = !rvalid;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (takeRead) begin
      rvalid <= 1'b1;
      rdata <= readMux;
      rresp <= (rdIsId || rdIsEmu || rdIsMap) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Loopback test mode
  // ***************************************************************
  // With test mode off the path bit is stored but has no effect.
  wire loopMode_t next_loopMode = '{active: emuCtl.loopEnable,
                                    internalPath: emuCtl.loopEnable && emuCtl.loopPath,
                                    externalPath: emuCtl.loopEnable && !emuCtl.loopPath};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      loopMode <= '0;
    end else begin
      loopMode <= next_loopMode;
    end
  end

  // ***************************************************************
  // Emulation halt
  // ***************************************************************
  logic haltSync;
  haltState_t haltState;
  haltState_t next_haltState;
  haltVec_t next_haltVec;

  bit_synchronizer haltSyncer (
    .mclk(mclk),
    .rstn(rstn),
    .asyncIn(haltRequest),
    .syncOut(haltSync)
  );

  // A dropped request or a late free-run setting releases the units at once.
  wire haltWanted = haltSync && !emuCtl.freeRun;

  always_comb begin
    next_haltState = haltState;
    unique case (haltState)
      RUNNING: begin
        if (haltWanted) next_haltState = WAIT_FRAME;
      end
      WAIT_FRAME: begin
        if (!haltWanted) next_haltState = RUNNING;
        else if (frameDone) next_haltState = HALTED;
      end
      HALTED: begin
        if (!haltWanted) next_haltState = RUNNING;
      end
      default: next_haltState = RUNNING;
    endcase
  end

  assign next_haltVec = (next_haltState != HALTED) ? '0 :
                        emuCtl.haltScope ? haltVec_t'(5'b00011) :
                        haltVec_t'(5'b11111);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      haltState <= RUNNING;
      haltVec <= '0;
    end else begin
      haltState <= next_haltState;
      haltVec <= next_haltVec;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  id_read_value_a: assert property (takeRead && rdIsId |=> rdata == idWord)
    else $error("identification word read back wrong");
  emu_read_bits_a: assert property (takeRead && rdIsEmu |=>
      rdata[LOOP_EN_BIT] == emuCtl.loopEnable && rdata[FREE_RUN_BIT] == emuCtl.freeRun
      && rdata[15:2] == 14'h0000)
    else $error("control word read back wrong");
  loop_path_sel_a: assert property (emuCtl.loopEnable ##1 emuCtl.loopEnable |->
      loopMode.internalPath == $past(emuCtl.loopPath) && loopMode.active)
    else $error("loopback path does not follow select bit");
  loop_off_ignored_a: assert property ($past(!emuCtl.loopEnable) |->
      !loopMode.active && !loopMode.internalPath && !loopMode.externalPath)
    else $error("loopback active in normal mode");
  loop_on_entry_a: assert property ($rose(emuCtl.loopEnable) |=> loopMode.active)
    else $error("loopback test mode not entered");
  halt_after_frame_a: assert property (haltVec != '0 |->
      $past(haltState == HALTED || (haltState == WAIT_FRAME && frameDone)))
    else $error("halt without frame completion");
  halt_full_scope_a: assert property (haltState == HALTED && !emuCtl.haltScope
      && haltWanted ##1 haltState == HALTED |-> haltVec == 5'b11111)
    else $error("full halt scope wrong");
  halt_rx_scope_a: assert property (haltState == HALTED && emuCtl.haltScope
      && haltWanted ##1 haltState == HALTED |-> haltVec == 5'b00011)
    else $error("receive-only halt scope wrong");
  free_run_a: assert property (emuCtl.freeRun [*2] |-> haltVec == '0)
    else $error("halt taken while free running");
  sync_delay_a: assert property ($rose(haltRequest) ##1 haltRequest ##1 haltRequest
      |-> haltSync)
    else $error("halt request not synchronised in two cycles");
  map_write_read_a: assert property (doWrite && wrIsMap && wrStrb == 4'hF |=>
      mapMem[$past(wrIndex)] == $past(wrData))
    else $error("bitmap word not written");

endmodule // emu_regs
`default_nettype wire

// ==== verification/tb_emu_regs.sv ====
// Self-checking bench for the identification and emulation register bank.
// Assumes the emu_regs package and modules are compiled ahead of this file.
`timescale 1ns/1ps
`default_nettype none
module tb_emu_regs
  import emu_regs_pkg::*;
;
  localparam logic [15:0] TB_ID = 16'h0A5A; // Arbitrary value.
  localparam logic [7:0] TB_MAJOR = 8'h0C; // Arbitrary value.
  localparam logic [7:0] TB_MINOR = 8'h03; // Arbitrary value.
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic haltRequest = 1'b0, frameDone = 1'b0;
  logic [1:0] mapReadTable = 2'h0;
  logic [2:0] mapReadWord = 3'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, mapReadData;
  loopMode_t loopMode;
  haltVec_t haltVec;
  int n_fail = 0;
  int n_tests = 0;

  always #5 mclk = ~mclk;

  emu_regs #(.MODULE_ID(TB_ID), .REV_MAJOR(TB_MAJOR), .REV_MINOR(TB_MINOR)) u_emu_regs (
    .mclk(mclk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .haltRequest(haltRequest), .frameDone(frameDone), .mapReadTable(mapReadTable),
    .mapReadWord(mapReadWord), .mapReadData(mapReadData), .loopMode(loopMode),
    .haltVec(haltVec));

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task timedOut;
    n_fail++;
    end_of_test();
  endtask

  task automatic waitCycles(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Address and data are offered together; each is dropped at its own handshake.
  task automatic busWrite(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
    int i;
    logic aTake, wTake, aDone, wDone;
    aDone = 1'b0;
    wDone = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; !(aDone && wDone); i++) begin
      if (i == 50) timedOut();
      @(negedge mclk);
      aTake = awvalid && awready;
      wTake = wvalid && wready;
      @(posedge mclk);
      if (aTake) begin
        awvalid <= 1'b0;
        aDone = 1'b1;
      end
      if (wTake) begin
        wvalid <= 1'b0;
        wDone = 1'b1;
      end
    end
    aTake = 1'b0;
    for (i = 0; !aTake; i++) begin
      if (i == 50) timedOut();
      @(negedge mclk);
      aTake = bvalid;
      if (aTake) check({30'd0, bresp}, {30'd0, er});
      @(posedge mclk);
    end
    bready <= 1'b0;
    // One idle edge keeps a following call from re-raising bready in this time step.
    @(posedge mclk);
  endtask

  task automatic readCheck(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er);
    int i;
    logic take;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    take = 1'b0;
    for (i = 0; !take; i++) begin
      if (i == 50) timedOut();
      @(negedge mclk);
      take = arready;
      @(posedge mclk);
    end
    arvalid <= 1'b0;
    take = 1'b0;
    for (i = 0; !take; i++) begin
      if (i == 50) timedOut();
      @(negedge mclk);
      take = rvalid;
      d = rdata;
      r = rresp;
      @(posedge mclk);
    end
    rready <= 1'b0;
    @(posedge mclk);
    check(d, exp);
    check({30'd0, r}, {30'd0, er});
  endtask

  task automatic framePulse(input logic [4:0] exp);
    frameDone <= 1'b1;
    @(posedge mclk);
    frameDone <= 1'b0;
    @(negedge mclk);
    check({27'd0, haltVec}, {27'd0, exp});
    @(posedge mclk);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic idAndControl;
    readCheck(ID_OFFSET, {TB_ID, TB_MAJOR, TB_MINOR}, RESP_OKAY);
    readCheck(EMU_OFFSET, 32'h0000_0000, RESP_OKAY);
    busWrite(ID_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    readCheck(ID_OFFSET, {TB_ID, TB_MAJOR, TB_MINOR}, RESP_OKAY);
    busWrite(EMU_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    readCheck(EMU_OFFSET, 32'h01F3_0003, RESP_OKAY);
    busWrite(EMU_OFFSET, 32'h0000_0000, 4'hF, RESP_OKAY);
  endtask

  task automatic loopModes;
    logic [31:0] ctl[3] = '{32'h0002_0000, 32'h0001_0000, 32'h0003_0000};
    logic [2:0] exp[3] = '{3'b000, 3'b101, 3'b110};
    for (int k = 0; k < 3; k++) begin
      busWrite(EMU_OFFSET, ctl[k], 4'hF, RESP_OKAY);
      waitCycles(2);
      check({29'd0, loopMode}, {29'd0, exp[k]});
    end
    busWrite(EMU_OFFSET, 32'h0000_0000, 4'hF, RESP_OKAY);
  endtask

  // The request must wait for a frame end; the scope bit is read live.
  task automatic haltFlow;
    haltRequest <= 1'b1;
    waitCycles(6);
    check({27'd0, haltVec}, 32'h0000_0000);
    framePulse(5'b11111);
    busWrite(EMU_OFFSET, 32'h0000_0002, 4'hF, RESP_OKAY);
    waitCycles(2);
    check({27'd0, haltVec}, 32'h0000_0003);
    busWrite(EMU_OFFSET, 32'h0000_0003, 4'hF, RESP_OKAY);
    waitCycles(2);
    check({27'd0, haltVec}, 32'h0000_0000);
    framePulse(5'b00000);
    busWrite(EMU_OFFSET, 32'h0000_0002, 4'hF, RESP_OKAY);
    waitCycles(2);
    framePulse(5'b00011);
    haltRequest <= 1'b0;
    waitCycles(5);
    check({27'd0, haltVec}, 32'h0000_0000);
    busWrite(EMU_OFFSET, 32'h0000_0000, 4'hF, RESP_OKAY);
  endtask

  task automatic bitmaps;
    logic [15:0] base[4] = '{TX_MAP_A, TX_MAP_B, RX_MAP_A, RX_MAP_B};
    logic [31:0] d;
    for (int t = 0; t < 4; t++) begin
      for (int w = 0; w < 8; w += 7) begin
        d = {8'h5A, 8'(t), 8'(w), 8'hC3};
        busWrite(base[t] + 16'(w * 4), d, 4'hF, RESP_OKAY);
        readCheck(base[t] + 16'(w * 4), d, RESP_OKAY);
        mapReadTable <= 2'(t);
        mapReadWord <= 3'(w);
        waitCycles(2);
        check(mapReadData, d);
      end
      readCheck(base[t] + 16'h000C, MAP_RESET, RESP_OKAY);
    end
    busWrite(TX_MAP_A + 16'h0004, 32'hFFFF_FFFF, 4'b0001, RESP_OKAY);
    readCheck(TX_MAP_A + 16'h0004, 32'h0000_00FF, RESP_OKAY);
    readCheck(16'h8020, 32'h0000_0000, RESP_SLVERR);
    readCheck(16'hC020, 32'h0000_0000, RESP_SLVERR);
    readCheck(16'h8002, 32'h0000_0000, RESP_SLVERR);
    busWrite(16'h0008, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    readCheck(16'h0008, 32'h0000_0000, RESP_SLVERR);
  endtask

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check({29'd0, loopMode}, 32'h0000_0000);
    check({27'd0, haltVec}, 32'h0000_0000);
    idAndControl();
    loopModes();
    haltFlow();
    bitmaps();
    end_of_test();
  end
endmodule // tb_emu_regs
`default_nettype wire
